/* design/aocs_pkg.sv */
// Purpose: shared constants and types of the aux output condition selector
// Assumes: 100 MHz control clock, frequencies and currents as unsigned codes
// Notes: register offsets are byte addresses on the Avalon-MM slave
package aocs_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int IOL_WARN_MS_DEF = 60000;
   localparam int INTERLOCK_MS_DEF = 500;
   localparam int IOL_PCT = 110;
   localparam int PCT_BASE = 100;
   localparam int HALF_SHIFT = 1;
   localparam int N_AUX = 4;

   localparam logic [7:0] OFS_AUX0 = 8'h00;
   localparam logic [7:0] OFS_AUX1 = 8'h04;
   localparam logic [7:0] OFS_AUX2 = 8'h08;
   localparam logic [7:0] OFS_AUX3 = 8'h0C;
   localparam logic [7:0] OFS_RELAY = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_FAN = 8'h18;
   localparam logic [7:0] OFS_DET_FREQ = 8'h1C;
   localparam logic [7:0] OFS_BW = 8'h20;
   localparam logic [7:0] OFS_OL_LEVEL = 8'h24;
   localparam logic [7:0] OFS_OL_TIME = 8'h28;
   localparam logic [7:0] OFS_ON_DLY = 8'h2C;
   localparam logic [7:0] OFS_OFF_DLY = 8'h30;
   localparam logic [7:0] OFS_EVENT = 8'h34;

   localparam logic [7:0] RST_AUX = 8'h00;
   localparam logic [2:0] RST_RELAY = 3'h2;
   localparam logic [1:0] RST_FAN = 2'h0;

   localparam int RLY_UV_BIT = 0;
   localparam int RLY_TRIP_BIT = 1;
   localparam int RLY_RETRY_BIT = 2;

   localparam logic [1:0] FAN_POWER_ON = 2'h0;
   localparam logic [1:0] FAN_RUN = 2'h1;
   localparam logic [1:0] FAN_TEMP = 2'h2;

   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_UV = 2'h1;
   localparam logic [1:0] CAUSE_TRIP = 2'h2;
   localparam logic [1:0] CAUSE_RETRY = 2'h3;

   typedef enum logic [7:0] {
      M_NONE = 8'h00, M_ARRIVAL = 8'h01, M_LEVEL = 8'h02, M_BAND = 8'h03,
      M_THRESH = 8'h04, M_THRESH_INV = 8'h05, M_OL_WARN = 8'h06,
      M_DRV_OL = 8'h07, M_STALL = 8'h08, M_BUS_OV = 8'h09,
      M_BUS_UV = 8'h0A, M_OVERHEAT = 8'h0B, M_LOST_REF = 8'h0C,
      M_RUN = 8'h0D, M_STOP = 8'h0E, M_STEADY = 8'h0F, M_INV_LINE = 8'h10,
      M_COMMERCIAL_LINE_SIGNAL = 8'h11, M_SEARCH = 8'h12, M_READY = 8'h13, M_MMC = 8'h14
   } aocs_mode_t;

   typedef enum logic [3:0] {
      X_INV = 4'h1, X_GAP_COMM = 4'h2, X_COMM = 4'h4, X_GAP_INV = 4'h8
   } aocs_xchg_t;

   typedef struct packed {
      logic stall;
      logic bus_ov;
      logic bus_uv;
      logic overheat;
      logic ref_lost;
      logic running;
      logic accel;
      logic decel;
      logic searching;
      logic ready;
      logic exchange;
      logic uv_trip;
      logic fault_trip;
      logic emergency_disable;
      logic retry_zero;
      logic auto_retry;
      logic fan_temp_hot;
      logic [2:0] extension_out;
   } aocs_drv_t;
endpackage

/* design/aocs_top.sv */
// Purpose: aux contact condition selector, fault relay, status, fan control
// Assumes: all drive inputs synchronous to CLK_I; Avalon-MM slave registers
// Notes: time bases count in milliseconds from one shared prescaler
//
// Contract
// - contact follows selected condition; none keeps open
// - arrival: |ref-out| within half bandwidth
// - level: arrival and |out-det| within half bandwidth
// - band: out within half bandwidth of det
// - threshold: close at det, hold above det-bw/2
// - inverted threshold is complement of threshold
// - overload warning after level held for time
// - drive overload 110% for 60s, trip later
// - stall mode follows stall prevention
// - bus over and under voltage modes
// - overheat mode follows heat sink indication
// - lost reference mode follows lost detection
// - run closes running, stop closes stopped
// - steady closes at constant running speed
// - search and ready modes follow inputs
// - line exchange keeps 500ms interlock gap
// - relay bit1 undervoltage, bit2 other faults
// - relay bit3 retry exhausted, not during retry
// - relay priority bit1, then bit2, then bit3
// - status word: aux, extension, relay bits
// - relay on and off delays, default zero
// - fan mode: power, running, temperature
// - selector codes 16 and 17 for exchange
`timescale 1ns/1ps
module aocs_top
#(
   parameter int FW = 16,
   parameter int MS_CYCLES = aocs_pkg::MS_CYCLES_DEF,
   parameter int IOL_WARN_MS = aocs_pkg::IOL_WARN_MS_DEF,
   parameter int INTERLOCK_MS = aocs_pkg::INTERLOCK_MS_DEF
)
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic [FW-1:0] REF_FREQ_I,
   input wire logic [FW-1:0] OUT_FREQ_I,
   input wire logic [FW-1:0] OUT_CURRENT_I,
   input wire logic [FW-1:0] RATED_CURRENT_I,
   input wire aocs_pkg::aocs_drv_t DRV_I,
   output logic [3:0] AUX_CONTACT_O,
   output logic FAULT_RELAY_O,
   output logic FAN_ON_O,
   output logic DRV_OL_TRIP_O,
   output logic [7:0] OUT_STATUS_O
);
   import aocs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [N_AUX-1:0][7:0] aux_mode;
      logic [2:0] relay_mode;
      logic [1:0] fan_sel;
      logic [FW-1:0] det_freq;
      logic [FW-1:0] bandwidth;
      logic [FW-1:0] ol_level;
      logic [15:0] ol_time_ms;
      logic [15:0] on_dly_ms;
      logic [15:0] off_dly_ms;
      logic [31:0] ms_div;
      logic [15:0] ol_cnt;
      logic [31:0] iol_cnt;
      logic [15:0] relay_cnt;
      logic [31:0] xchg_cnt;
      aocs_xchg_t xchg;
      logic thresh;
      logic relay;
      logic [1:0] cause;
      logic iol_trip;
      logic [N_AUX-1:0] aux;
      logic fan;
      logic ack;
      logic [31:0] rdata;
   } aocs_state_t;

   localparam aocs_state_t ST_RESET = '{
      aux_mode: {N_AUX{RST_AUX}},
      relay_mode: RST_RELAY,
      fan_sel: RST_FAN,
      xchg: X_INV,
      default: '0
   };

   aocs_state_t st_r;
   aocs_state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [FW-1:0] absdiff(input logic [FW-1:0] a,
                                             input logic [FW-1:0] b);
      absdiff = (a >= b) ? a - b : b - a;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      merge = m;
   endfunction

   logic [FW-1:0] half_bw;
   logic arrival;
   logic level_hit;
   logic band_hit;
   logic thresh_low;
   logic [2*FW+7:0] cur_scaled;
   logic [2*FW+7:0] lim_scaled;
   logic iol_over;
   logic ol_over;
   logic tick;
   logic warn_ol;
   logic warn_iol;
   logic steady;
   logic demand;
   logic [1:0] cause;
   logic [15:0] dly;
   logic [N_AUX-1:0] cond;
   logic [31:0] rd_mux;
   logic [31:0] bus_word;
   logic [7:0] status;
   logic inv_line;
   logic commercial_line_signal;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      st_nxt = st_r;
      tick = (st_r.ms_div == 32'(MS_CYCLES - 1));
      st_nxt.ms_div = tick ? '0 : st_r.ms_div + 32'h1;

      // frequency detection
      half_bw = st_r.bandwidth >> HALF_SHIFT;
      arrival = absdiff(REF_FREQ_I, OUT_FREQ_I) <= half_bw;
      level_hit = arrival &&
                  (absdiff(OUT_FREQ_I, st_r.det_freq) <= half_bw);
      band_hit = absdiff(st_r.det_freq, OUT_FREQ_I) <= half_bw;
      // with det at or below half bandwidth the hold term is always true, so the latch never releases
      thresh_low = (st_r.det_freq > half_bw) ?
                   (OUT_FREQ_I > st_r.det_freq - half_bw) : 1'b1;
      // hysteresis latch: closing needs det, holding needs det-bw/2
      st_nxt.thresh = (OUT_FREQ_I >= st_r.det_freq) ||
                      (st_r.thresh && thresh_low);

      // overload warning
      ol_over = OUT_CURRENT_I >= st_r.ol_level;
      if (!ol_over)
      begin
         st_nxt.ol_cnt = '0;
      end
      else if (tick && (st_r.ol_cnt < st_r.ol_time_ms))
      begin
         st_nxt.ol_cnt = st_r.ol_cnt + 16'h1;
      end
      warn_ol = ol_over && (st_r.ol_cnt >= st_r.ol_time_ms);

      // drive overload: warn after one period, trip after a second one
      cur_scaled = (2*FW+8)'(OUT_CURRENT_I) * (2*FW+8)'(PCT_BASE);
      lim_scaled = (2*FW+8)'(RATED_CURRENT_I) * (2*FW+8)'(IOL_PCT);
      iol_over = cur_scaled > lim_scaled;
      if (!iol_over)
      begin
         st_nxt.iol_cnt = '0;
      end
      else if (tick && (st_r.iol_cnt < 32'(2 * IOL_WARN_MS)))
      begin
         st_nxt.iol_cnt = st_r.iol_cnt + 32'h1;
      end
      warn_iol = iol_over && (st_r.iol_cnt >= 32'(IOL_WARN_MS));
      // trip latches until reset; cutting the output is up to the drive
      if (iol_over && (st_r.iol_cnt >= 32'(2 * IOL_WARN_MS)))
      begin
         st_nxt.iol_trip = 1'b1;
      end

      steady = DRV_I.running && !DRV_I.accel && !DRV_I.decel;

      // line exchange sequencer
      case (st_r.xchg)
         X_INV:
         begin
            st_nxt.xchg_cnt = '0;
            if (DRV_I.exchange)
            begin
               st_nxt.xchg = X_GAP_COMM;
            end
         end
         X_GAP_COMM:
         begin
            if (!DRV_I.exchange)
            begin
               st_nxt.xchg = X_INV;
            end
            else if (st_r.xchg_cnt >= 32'(INTERLOCK_MS))
            begin
               st_nxt.xchg = X_COMM;
            end
            else if (tick)
            begin
               st_nxt.xchg_cnt = st_r.xchg_cnt + 32'h1;
            end
         end
         X_COMM:
         begin
            st_nxt.xchg_cnt = '0;
            if (!DRV_I.exchange)
            begin
               st_nxt.xchg = X_GAP_INV;
            end
         end
         X_GAP_INV:
         begin
            if (DRV_I.exchange)
            begin
               st_nxt.xchg = X_COMM;
            end
            else if (st_r.xchg_cnt >= 32'(INTERLOCK_MS))
            begin
               st_nxt.xchg = X_INV;
            end
            else if (tick)
            begin
               st_nxt.xchg_cnt = st_r.xchg_cnt + 32'h1;
            end
         end
         default:
         begin
            st_nxt.xchg = X_INV;
         end
      endcase
      inv_line = (st_r.xchg == X_INV);
      commercial_line_signal = (st_r.xchg == X_COMM);

      // contact selection per channel
      for (int i = 0; i < N_AUX; i++)
      begin
         case (st_r.aux_mode[i])
            M_ARRIVAL: cond[i] = arrival;
            M_LEVEL: cond[i] = level_hit;
            M_BAND: cond[i] = band_hit;
            M_THRESH: cond[i] = st_r.thresh;
            M_THRESH_INV: cond[i] = !st_r.thresh;
            M_OL_WARN: cond[i] = warn_ol;
            M_DRV_OL: cond[i] = warn_iol;
            M_STALL: cond[i] = DRV_I.stall;
            M_BUS_OV: cond[i] = DRV_I.bus_ov;
            M_BUS_UV: cond[i] = DRV_I.bus_uv;
            M_OVERHEAT: cond[i] = DRV_I.overheat;
            M_LOST_REF: cond[i] = DRV_I.ref_lost;
            M_RUN: cond[i] = DRV_I.running;
            M_STOP: cond[i] = !DRV_I.running;
            M_STEADY: cond[i] = steady;
            M_INV_LINE: cond[i] = inv_line;
            M_COMMERCIAL_LINE_SIGNAL: cond[i] = commercial_line_signal;
            M_SEARCH: cond[i] = DRV_I.searching;
            M_READY: cond[i] = DRV_I.ready;
            // none, pump control and unknown codes leave the contact open
            default: cond[i] = 1'b0;
         endcase
      end
      st_nxt.aux = cond;

      // fault relay demand, first matching bit names the cause
      demand = 1'b1;
      if (st_r.relay_mode[RLY_UV_BIT] && DRV_I.uv_trip)
      begin
         cause = CAUSE_UV;
      end
      else if (st_r.relay_mode[RLY_TRIP_BIT] && DRV_I.fault_trip &&
               !DRV_I.uv_trip && !DRV_I.emergency_disable)
      begin
         cause = CAUSE_TRIP;
      end
      else if (st_r.relay_mode[RLY_RETRY_BIT] && DRV_I.retry_zero &&
               !DRV_I.auto_retry)
      begin
         cause = CAUSE_RETRY;
      end
      else
      begin
         cause = CAUSE_NONE;
         demand = 1'b0;
      end
      if (demand)
      begin
         st_nxt.cause = cause;
      end

      // relay delay: a bounce shorter than the delay restarts the count
      dly = demand ? st_r.on_dly_ms : st_r.off_dly_ms;
      if (demand == st_r.relay)
      begin
         st_nxt.relay_cnt = '0;
      end
      else if (st_r.relay_cnt >= dly)
      begin
         st_nxt.relay = demand;
         st_nxt.relay_cnt = '0;
      end
      else if (tick)
      begin
         st_nxt.relay_cnt = st_r.relay_cnt + 16'h1;
      end

      // cooling fan
      case (st_r.fan_sel)
         FAN_RUN: st_nxt.fan = DRV_I.running && (OUT_FREQ_I != '0);
         FAN_TEMP: st_nxt.fan = DRV_I.fan_temp_hot;
         default: st_nxt.fan = 1'b1;
      endcase

      status = {st_r.relay, DRV_I.extension_out, st_r.aux};

      // register read mux
      case (AVS_ADDRESS_I)
         OFS_AUX0: rd_mux = 32'(st_r.aux_mode[0]);
         OFS_AUX1: rd_mux = 32'(st_r.aux_mode[1]);
         OFS_AUX2: rd_mux = 32'(st_r.aux_mode[2]);
         OFS_AUX3: rd_mux = 32'(st_r.aux_mode[3]);
         OFS_RELAY: rd_mux = 32'(st_r.relay_mode);
         OFS_STATUS: rd_mux = 32'(status);
         OFS_FAN: rd_mux = 32'(st_r.fan_sel);
         OFS_DET_FREQ: rd_mux = 32'(st_r.det_freq);
         OFS_BW: rd_mux = 32'(st_r.bandwidth);
         OFS_OL_LEVEL: rd_mux = 32'(st_r.ol_level);
         OFS_OL_TIME: rd_mux = 32'(st_r.ol_time_ms);
         OFS_ON_DLY: rd_mux = 32'(st_r.on_dly_ms);
         OFS_OFF_DLY: rd_mux = 32'(st_r.off_dly_ms);
         OFS_EVENT: rd_mux = 32'({st_r.iol_trip, st_r.cause, st_r.xchg});
         default: rd_mux = '0;
      endcase

      // bus: first cycle stalls and samples, second cycle completes
      st_nxt.ack = (AVS_READ_I || AVS_WRITE_I) && !st_r.ack;
      if (AVS_READ_I && !st_r.ack)
      begin
         st_nxt.rdata = rd_mux;
      end
      bus_word = merge(rd_mux, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      if (AVS_WRITE_I && st_r.ack)
      begin
         case (AVS_ADDRESS_I)
            OFS_AUX0: st_nxt.aux_mode[0] = bus_word[7:0];
            OFS_AUX1: st_nxt.aux_mode[1] = bus_word[7:0];
            OFS_AUX2: st_nxt.aux_mode[2] = bus_word[7:0];
            OFS_AUX3: st_nxt.aux_mode[3] = bus_word[7:0];
            OFS_RELAY: st_nxt.relay_mode = bus_word[2:0];
            OFS_FAN: st_nxt.fan_sel = bus_word[1:0];
            OFS_DET_FREQ: st_nxt.det_freq = bus_word[FW-1:0];
            OFS_BW: st_nxt.bandwidth = bus_word[FW-1:0];
            OFS_OL_LEVEL: st_nxt.ol_level = bus_word[FW-1:0];
            OFS_OL_TIME: st_nxt.ol_time_ms = bus_word[15:0];
            OFS_ON_DLY: st_nxt.on_dly_ms = bus_word[15:0];
            OFS_OFF_DLY: st_nxt.off_dly_ms = bus_word[15:0];
            default: st_nxt.ack = st_nxt.ack;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         st_r <= ST_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !st_r.ack;
   assign AVS_READDATA_O = st_r.rdata;
   assign AUX_CONTACT_O = st_r.aux;
   assign FAULT_RELAY_O = st_r.relay;
   assign FAN_ON_O = st_r.fan;
   assign DRV_OL_TRIP_O = st_r.iol_trip;
   assign OUT_STATUS_O = {st_r.relay, DRV_I.extension_out, st_r.aux};
endmodule

/* testbench/aocs_contact_model.sv */
// Purpose: line exchange contactor pair driven by two aux contacts
// Assumes: contact 0 feeds the drive line, contact 1 the commercial line
// Notes: while line_pair_i is set, flags any clock edge at which both contactors would pull in together
`timescale 1ns/1ps
module aocs_contact_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic line_pair_i,
   input wire logic [3:0] contact_i,
   output logic overlap_o
);
   // both lines at once would short the drive output to the mains
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         overlap_o <= 1'b0;
      else if (line_pair_i && contact_i[0] && contact_i[1])
         overlap_o <= 1'b1;
   end
endmodule

/* testbench/aocs_top_sva.sv */
// Purpose: port-level checks of the aux output selector
// Assumes: aux mode 0 tracked from accepted bus writes
// Notes: bound to aocs_top from the test top
`timescale 1ns/1ps
module aocs_top_sva
#(
   parameter int FW = 16
)
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic [FW-1:0] OUT_CURRENT_I,
   input wire logic [FW-1:0] RATED_CURRENT_I,
   input wire aocs_pkg::aocs_drv_t DRV_I,
   input wire logic [3:0] AUX_CONTACT_O,
   input wire logic FAULT_RELAY_O,
   input wire logic DRV_OL_TRIP_O,
   input wire logic [7:0] OUT_STATUS_O
);
   import aocs_pkg::*;
   logic [7:0] mode0_r;
   logic over_w;
   assign over_w = (32'(OUT_CURRENT_I) * 32'(PCT_BASE)) >
                   (32'(RATED_CURRENT_I) * 32'(IOL_PCT));
   // shadow only takes writes at the accepting edge
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         mode0_r <= RST_AUX;
      else if (AVS_WRITE_I && !AVS_WAITREQUEST_O &&
               AVS_ADDRESS_I == OFS_AUX0 && AVS_BYTEENABLE_I[0])
         mode0_r <= AVS_WRITEDATA_I[7:0];
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   ////////////////////////////////////////////////////////////
   a_wait_one_cycle: assert property ((AVS_READ_I || AVS_WRITE_I) &&
      AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("waitrequest held over one cycle");
   a_idle_no_wait: assert property (!(AVS_READ_I || AVS_WRITE_I)
      |-> !AVS_WAITREQUEST_O) else $error("waitrequest while idle");
   a_status_own_bits: assert property (OUT_STATUS_O[3:0] == AUX_CONTACT_O
      && OUT_STATUS_O[7] == FAULT_RELAY_O) else $error("status aux or relay");
   a_status_ext_bits: assert property (OUT_STATUS_O[6:4] ==
      DRV_I.extension_out) else $error("status extension bits");
   a_trip_sticky: assert property (DRV_OL_TRIP_O |=> DRV_OL_TRIP_O)
      else $error("overload trip dropped");
   a_trip_cause: assert property ($rose(DRV_OL_TRIP_O) |-> $past(over_w))
      else $error("overload trip without overcurrent");
   a_none_open: assert property (mode0_r == M_NONE &&
      $past(mode0_r) == M_NONE |-> !AUX_CONTACT_O[0])
      else $error("contact closed with no mode");
   a_run_follow: assert property (mode0_r == M_RUN &&
      $past(mode0_r) == M_RUN |-> AUX_CONTACT_O[0] == $past(DRV_I.running))
      else $error("run contact wrong");
   a_stop_follow: assert property (mode0_r == M_STOP &&
      $past(mode0_r) == M_STOP |-> AUX_CONTACT_O[0] == !$past(DRV_I.running))
      else $error("stop contact wrong");
   a_stall_follow: assert property (mode0_r == M_STALL &&
      $past(mode0_r) == M_STALL |-> AUX_CONTACT_O[0] == $past(DRV_I.stall))
      else $error("stall contact wrong");
endmodule

/* testbench/aocs_top_test.sv */
// Purpose: directed test of the aux output selector
// Assumes: shortened ms prescaler and timers
// Notes: bus tasks hold each request until waitrequest is low
`timescale 1ns/1ps
module aocs_top_test;
   import aocs_pkg::*;
   localparam int FW = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, q;
   logic waitreq, relay, fan, trip, overlap;
   logic line_pair = 1'b0;
   logic [FW-1:0] reff = 16'h0;
   logic [FW-1:0] outf = 16'h0;
   logic [FW-1:0] cur = 16'h0;
   logic [FW-1:0] rated = 16'h0;
   aocs_drv_t drv = '0;
   aocs_drv_t pat [3];
   logic [3:0] aux;
   logic [7:0] status;
   int num_errors = 0;
   int checks = 0;
   aocs_mode_t modes [11] = '{M_RUN, M_BUS_OV, M_BUS_UV, M_OVERHEAT,
      M_STOP, M_LOST_REF, M_STEADY, M_SEARCH, M_STALL, M_READY, M_NONE};
   int ft [12][4] = '{'{1,100,90,1}, '{1,100,89,0}, '{1,100,110,1},
      '{1,100,111,0}, '{2,90,90,1}, '{2,89,89,0}, '{2,95,89,0},
      '{2,111,111,0}, '{3,0,110,1}, '{3,0,111,0}, '{3,0,90,1}, '{3,0,89,0}};
   int th [5] = '{0, 99, 100, 91, 90};
   logic [4:0] th_exp = 5'b01100;
   always #5 clk = ~clk;
   aocs_top #(.FW(FW), .MS_CYCLES(10), .IOL_WARN_MS(5), .INTERLOCK_MS(4))
   dut_u (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .REF_FREQ_I(reff), .OUT_FREQ_I(outf), .OUT_CURRENT_I(cur),
      .RATED_CURRENT_I(rated), .DRV_I(drv), .AUX_CONTACT_O(aux),
      .FAULT_RELAY_O(relay), .FAN_ON_O(fan), .DRV_OL_TRIP_O(trip),
      .OUT_STATUS_O(status));
   aocs_contact_model model_u (.clk_i(clk), .rst_i(rst),
      .line_pair_i(line_pair), .contact_i(aux), .overlap_o(overlap));
   ////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   // one transfer; waitrequest and read data taken at the rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitreq !== 1'b0 && n < 50);
      if (waitreq !== 1'b0)
         num_errors++;
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input string s, input logic [7:0] a,
                         input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, e, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic put(input aocs_drv_t d);
      @(posedge clk);
      drv <= d;
   endtask
   function automatic logic exp_mode(aocs_mode_t m, aocs_drv_t d);
      case (m)
         M_STALL: return d.stall;
         M_BUS_OV: return d.bus_ov;
         M_BUS_UV: return d.bus_uv;
         M_OVERHEAT: return d.overheat;
         M_LOST_REF: return d.ref_lost;
         M_RUN: return d.running;
         M_STOP: return !d.running;
         M_STEADY: return d.running && !d.accel && !d.decel;
         M_SEARCH: return d.searching;
         M_READY: return d.ready;
         default: return 1'b0;
      endcase
   endfunction
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim();
   end
   initial
   begin
      pat[0] = '0;
      pat[1] = '0;
      pat[1].running = 1'b1;
      pat[2] = '1;
      pat[2].exchange = 1'b0;
      {pat[2].uv_trip, pat[2].fault_trip, pat[2].retry_zero} = 3'b000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      put('{extension_out: 3'b101, default: 1'b0});
      cyc(2);
      chk("fan", 1, fan);
      for (int i = 0; i < 4; i++)
         rd_chk("aux mode", OFS_AUX0 + 8'(4 * i), 32'(RST_AUX));
      rd_chk("relay mode", OFS_RELAY, 32'(RST_RELAY));
      rd_chk("fan sel", OFS_FAN, 32'(RST_FAN));
      rd_chk("status", OFS_STATUS, 32'h50);
      wr_reg(OFS_STATUS, 32'hFF);
      wr_reg(8'h3C, 32'hFF);
      rd_chk("status ro", OFS_STATUS, 32'h50);
      rd_chk("unmapped", 8'h3C, 32'h0);
      for (int i = 0; i < 11; i++)
      begin
         wr_reg(OFS_AUX0 + 8'(4 * (i % 4)), 32'(modes[i]));
         for (int j = 0; j < 3; j++)
         begin
            put(pat[j]);
            cyc(3);
            chk("aux simple", exp_mode(modes[i], pat[j]), aux[i % 4]);
         end
      end
      put('0);
      wr_reg(OFS_DET_FREQ, 32'd100);
      wr_reg(OFS_BW, 32'd20);
      for (int k = 0; k < 12; k++)
      begin
         wr_reg(OFS_AUX3, 32'(ft[k][0]));
         reff <= 16'(ft[k][1]);
         outf <= 16'(ft[k][2]);
         cyc(3);
         chk("aux freq", 32'(ft[k][3]), aux[3]);
      end
      wr_reg(OFS_AUX1, 32'(M_THRESH));
      wr_reg(OFS_AUX2, 32'(M_THRESH_INV));
      for (int k = 0; k < 5; k++)
      begin
         outf <= 16'(th[k]);
         cyc(3);
         chk("aux thresh", th_exp[k], aux[1]);
         chk("aux thresh inv", !th_exp[k], aux[2]);
      end
      wr_reg(OFS_AUX0, 32'(M_INV_LINE));
      wr_reg(OFS_AUX1, 32'(M_COMMERCIAL_LINE_SIGNAL));
      cyc(3);
      chk("line pair", 2'b01, aux[1:0]);
      line_pair <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         put('{exchange: !k[0], default: 1'b0});
         cyc(20);
         chk("line gap", 2'b00, aux[1:0]);
         cyc(40);
         chk("line pair", k[0] ? 2'b01 : 2'b10, aux[1:0]);
      end
      chk("line overlap", 0, overlap);
      put('{fault_trip: 1'b1, default: 1'b0});
      cyc(3);
      chk("relay trip", 1, relay);
      put('{uv_trip: 1'b1, default: 1'b0});
      cyc(3);
      chk("relay uv mode2", 0, relay);
      wr_reg(OFS_RELAY, 32'h1);
      cyc(3);
      chk("relay uv mode1", 1, relay);
      put('{fault_trip: 1'b1, default: 1'b0});
      cyc(3);
      chk("relay trip mode1", 0, relay);
      wr_reg(OFS_RELAY, 32'h4);
      put('{retry_zero: 1'b1, default: 1'b0});
      cyc(3);
      chk("relay retry", 1, relay);
      put('{retry_zero: 1'b1, auto_retry: 1'b1, default: 1'b0});
      cyc(3);
      chk("relay auto retry", 0, relay);
      wr_reg(OFS_RELAY, 32'h7);
      put('{uv_trip: 1'b1, fault_trip: 1'b1, retry_zero: 1'b1,
            default: 1'b0});
      cyc(3);
      bus(1'b0, OFS_EVENT, 32'h0);
      chk("relay cause", CAUSE_UV, q[5:4]);
      put('{fault_trip: 1'b1, retry_zero: 1'b1, default: 1'b0});
      cyc(3);
      bus(1'b0, OFS_EVENT, 32'h0);
      chk("relay cause", CAUSE_TRIP, q[5:4]);
      put('0);
      wr_reg(OFS_ON_DLY, 32'd3);
      wr_reg(OFS_OFF_DLY, 32'd2);
      put('{fault_trip: 1'b1, default: 1'b0});
      cyc(15);
      chk("relay on delay", 0, relay);
      cyc(30);
      chk("relay on delay", 1, relay);
      put('0);
      cyc(5);
      chk("relay off delay", 1, relay);
      cyc(30);
      chk("relay off delay", 0, relay);
      wr_reg(OFS_FAN, 32'(FAN_RUN));
      for (int k = 0; k < 4; k++)
      begin
         if (k == 2)
            wr_reg(OFS_FAN, 32'(FAN_TEMP));
         put('{running: (k != 2) && k[0], fan_temp_hot: (k == 3),
               default: 1'b0});
         cyc(3);
         chk("fan", k[0], fan);
      end
      wr_reg(OFS_AUX0, 32'(M_OL_WARN));
      wr_reg(OFS_OL_LEVEL, 32'd200);
      wr_reg(OFS_OL_TIME, 32'd2);
      cur <= 16'd200;
      cyc(3);
      chk("overload early", 0, aux[0]);
      cyc(40);
      chk("overload warn", 1, aux[0]);
      cur <= 16'd199;
      cyc(3);
      chk("overload drop", 0, aux[0]);
      wr_reg(OFS_AUX0, 32'(M_DRV_OL));
      rated <= 16'd100;
      cur <= 16'd110;
      cyc(80);
      chk("drive ol at limit", 0, aux[0]);
      cur <= 16'd111;
      cyc(20);
      chk("drive ol early", 0, aux[0]);
      cyc(50);
      chk("drive ol warn", 1, aux[0]);
      chk("drive ol trip early", 0, trip);
      cyc(60);
      chk("drive ol trip", 1, trip);
      end_sim();
   end
endmodule
bind aocs_top aocs_top_sva #(.FW(FW)) sva_u (.CLK_I(CLK_I), .RST_I(RST_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
   .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .OUT_CURRENT_I(OUT_CURRENT_I), .RATED_CURRENT_I(RATED_CURRENT_I),
   .DRV_I(DRV_I), .AUX_CONTACT_O(AUX_CONTACT_O),
   .FAULT_RELAY_O(FAULT_RELAY_O), .DRV_OL_TRIP_O(DRV_OL_TRIP_O),
   .OUT_STATUS_O(OUT_STATUS_O));
